// *** hw/dac_ctrl_pkg.sv ***
// Purpose: shared constants for the two-channel converter control block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes:   register indices kept as printed; byte address is four times index
package dac_ctrl_pkg;
  // printed offsets, kept as indices (not multiples of four)
  localparam logic [19:0] IDX_CODE_CH0   = 20'hFFF9C;
  localparam logic [19:0] IDX_CODE_CH1   = 20'hFFF9D;
  localparam logic [19:0] IDX_CONTROL    = 20'hFFF9E;
  localparam logic [19:0] IDX_STBY_CTRL  = 20'hEE01A;
  localparam int          ADDR_W         = 22;
  // reset values
  localparam logic [7:0]  CODE_RST       = 8'h00;
  localparam logic [7:0]  CONTROL_RST    = 8'h1F;
  localparam logic [7:0]  STBY_CTRL_RST  = 8'hFE;
  // field positions
  localparam int          BIT_OE1        = 7;
  localparam int          BIT_OE0        = 6;
  localparam int          BIT_JOINT      = 5;
  localparam int          BIT_KEEP       = 0;
  // reserved bits read as one
  localparam logic [7:0]  CONTROL_RSVD   = 8'h1F;
  localparam logic [7:0]  STBY_RSVD      = 8'hFE;
  // power states
  typedef enum logic [1:0] {
    PWR_RUN,
    PWR_SW_STBY,
    PWR_HW_STBY
  } pwr_e;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [19:0] idx);
    byte_addr = {idx, 2'b00};
  endfunction : byte_addr
endpackage : dac_ctrl_pkg

// *** hw/dac_conv_decode.sv ***
// Purpose: decode conversion and pin-drive enables from control bits
// Assumes: enable inputs are register outputs of the control register
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module dac_conv_decode (
  input  wire logic oe0_i,
  input  wire logic oe1_i,
  input  wire logic joint_i,
  input  wire logic out_ok_i,
  output logic      conv0_o,
  output logic      conv1_o,
  output logic      drive0_o,
  output logic      drive1_o
);
  logic any_oe;

  // RULE8 conversion enable decode
  // RULE7 grouping joins channels
  assign any_oe   = oe0_i | oe1_i;
  assign conv0_o  = out_ok_i & (oe0_i | (joint_i & any_oe));
  assign conv1_o  = out_ok_i & (oe1_i | (joint_i & any_oe));
  // RULE9 drive follows own enable
  // RULE15 cleared enable releases pin
  assign drive0_o = out_ok_i & oe0_i;
  assign drive1_o = out_ok_i & oe1_i;
endmodule : dac_conv_decode
`default_nettype wire

// *** hw/dac_wb_slave.sv ***
// Purpose: classic Wishbone handshake and address decode for four registers
// Assumes: single classic cycles; ack one cycle after stb, one cycle wide
// Notes:   unmapped addresses are acked and read as zero
`timescale 1ns/1ps
`default_nettype none
module dac_wb_slave
  import dac_ctrl_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              cyc_i,
  input  wire logic              stb_i,
  input  wire logic [ADDR_W-1:0] adr_i,
  output logic                   ack_o,
  output logic                   req_o,
  output logic [1:0]             sel_reg_o,
  output logic                   hit_o
);
  // request seen this cycle and not yet answered
  assign req_o = cyc_i & stb_i & ~ack_o;

  // ack pulse
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= req_o;
    end
  end

  // address decode
  always_comb begin
    hit_o     = 1'b1;
    sel_reg_o = 2'd0;
    if (adr_i == byte_addr(IDX_CODE_CH0)) begin
      sel_reg_o = 2'd0;
    end else if (adr_i == byte_addr(IDX_CODE_CH1)) begin
      sel_reg_o = 2'd1;
    end else if (adr_i == byte_addr(IDX_CONTROL)) begin
      sel_reg_o = 2'd2;
    end else if (adr_i == byte_addr(IDX_STBY_CTRL)) begin
      sel_reg_o = 2'd3;
    end else begin
      hit_o = 1'b0;
    end
  end
endmodule : dac_wb_slave
`default_nettype wire

// *** hw/dual_dac_control_regs.sv ***
// Purpose: register file and enable logic for a two-channel 8-bit converter
// Assumes: Wishbone classic slave; standby levels come from power control
// Notes:   outputs to the analog macro are registered
//
// Behaviour
// RULE1 - data register code feeds converter continuously
// RULE2 - codes clear on reset and standby
// RULE3 - keep bit set retains registers in software standby
// RULE4 - control register resets to 1F
// RULE5 - bit 7 enables channel 1
// RULE6 - bit 6 enables channel 0
// RULE7 - bit 5 groups both conversions
// RULE8 - enable decode table for both channels
// RULE9 - pin drive follows own enable only
// RULE10 - reserved bits ignore writes, read one
// RULE11 - standby control resets FE, survives software standby
// RULE12 - bit 0 governs output in software standby
// RULE13 - zero disables, one keeps output in standby
// RULE14 - new code converts at once
// RULE15 - cleared enable returns pin to input
// RULE16 - registered enables and codes next cycle
`timescale 1ns/1ps
`default_nettype none
module dual_dac_control_regs
  import dac_ctrl_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              srst_i,
  input  wire logic              sw_standby_i,
  input  wire logic              hw_standby_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [ADDR_W-1:0] wb_adr_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic [31:0]            wb_dat_o,
  output logic                   wb_ack_o,
  output logic                   conv_en0_o,
  output logic                   conv_en1_o,
  output logic                   analog_out_pin0_oe_o,
  output logic                   analog_out_pin1_oe_o,
  output logic [7:0]             code_ch0_o,
  output logic [7:0]             code_ch1_o,
  output logic                   stby_state_o
);
  logic [7:0] dac_code_ch0_r;
  logic [7:0] dac_code_ch1_r;
  logic       out_enable_ch0_r;
  logic       out_enable_ch1_r;
  logic       joint_conversion_r;
  logic       standby_output_keep_r;
  pwr_e       pwr_r;
  pwr_e       pwr_nxt;
  logic       req;
  logic       hit;
  logic [1:0] sel_reg;
  logic       wr;
  logic       init_regs;
  logic       out_ok;
  logic       conv0;
  logic       conv1;
  logic       drv0;
  logic       drv1;
  logic [7:0] rd_byte;

  dac_wb_slave u_bus (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .cyc_i     (wb_cyc_i),
    .stb_i     (wb_stb_i),
    .adr_i     (wb_adr_i),
    .ack_o     (wb_ack_o),
    .req_o     (req),
    .sel_reg_o (sel_reg),
    .hit_o     (hit)
  );

  // power state: hardware standby wins over software standby
  always_comb begin
    pwr_nxt = PWR_RUN;
    if (hw_standby_i) begin
      pwr_nxt = PWR_HW_STBY;
    end else if (sw_standby_i) begin
      pwr_nxt = PWR_SW_STBY;
    end
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      pwr_r <= PWR_RUN;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // RULE2 standby initialises registers
  // RULE3 keep bit retains in software standby
  always_comb begin
    case (pwr_nxt)
      PWR_HW_STBY: init_regs = 1'b1;
      PWR_SW_STBY: init_regs = ~standby_output_keep_r;
      default:     init_regs = 1'b0;
    endcase
  end

  // RULE13 output allowed only in run or kept standby
  always_comb begin
    case (pwr_r)
      PWR_RUN:     out_ok = 1'b1;
      PWR_SW_STBY: out_ok = standby_output_keep_r;
      default:     out_ok = 1'b0;
    endcase
  end

  // writes land on the ack edge, low byte lane
  assign wr = req & wb_we_i & hit & wb_sel_i[0];

  // RULE1 channel 0 data register
  // RULE14 new code takes effect at once
  always_ff @(posedge clock_i) begin
    if (srst_i || init_regs) begin
      dac_code_ch0_r <= CODE_RST;
    end else if (wr && sel_reg == 2'd0) begin
      dac_code_ch0_r <= wb_dat_i[7:0];
    end
  end

  // channel 1 data register
  always_ff @(posedge clock_i) begin
    if (srst_i || init_regs) begin
      dac_code_ch1_r <= CODE_RST;
    end else if (wr && sel_reg == 2'd1) begin
      dac_code_ch1_r <= wb_dat_i[7:0];
    end
  end

  // RULE4 control register reset
  // RULE5 channel 1 enable bit
  // RULE6 channel 0 enable bit
  always_ff @(posedge clock_i) begin
    if (srst_i || init_regs) begin
      out_enable_ch1_r   <= CONTROL_RST[BIT_OE1];
      out_enable_ch0_r   <= CONTROL_RST[BIT_OE0];
      joint_conversion_r <= CONTROL_RST[BIT_JOINT];
    end else if (wr && sel_reg == 2'd2) begin
      out_enable_ch1_r   <= wb_dat_i[BIT_OE1];
      out_enable_ch0_r   <= wb_dat_i[BIT_OE0];
      joint_conversion_r <= wb_dat_i[BIT_JOINT];
    end
  end

  // RULE11 standby control survives software standby
  // RULE12 keep bit write
  always_ff @(posedge clock_i) begin
    if (srst_i || pwr_nxt == PWR_HW_STBY) begin
      standby_output_keep_r <= STBY_CTRL_RST[BIT_KEEP];
    end else if (wr && sel_reg == 2'd3) begin
      standby_output_keep_r <= wb_dat_i[BIT_KEEP];
    end
  end

  dac_conv_decode u_dec (
    .oe0_i    (out_enable_ch0_r),
    .oe1_i    (out_enable_ch1_r),
    .joint_i  (joint_conversion_r),
    .out_ok_i (out_ok),
    .conv0_o  (conv0),
    .conv1_o  (conv1),
    .drive0_o (drv0),
    .drive1_o (drv1)
  );

  // RULE16 registered outputs to analog macro
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      conv_en0_o           <= 1'b0;
      conv_en1_o           <= 1'b0;
      analog_out_pin0_oe_o <= 1'b0;
      analog_out_pin1_oe_o <= 1'b0;
      code_ch0_o           <= CODE_RST;
      code_ch1_o           <= CODE_RST;
      stby_state_o         <= 1'b0;
    end else begin
      conv_en0_o           <= conv0;
      conv_en1_o           <= conv1;
      analog_out_pin0_oe_o <= drv0;
      analog_out_pin1_oe_o <= drv1;
      code_ch0_o           <= dac_code_ch0_r;
      code_ch1_o           <= dac_code_ch1_r;
      stby_state_o         <= (pwr_r != PWR_RUN);
    end
  end

  // RULE10 reserved bits read as one
  always_comb begin
    rd_byte = 8'h00;
    if (!hit) begin
      rd_byte = 8'h00;
    end else if (sel_reg == 2'd0) begin
      rd_byte = dac_code_ch0_r;
    end else if (sel_reg == 2'd1) begin
      rd_byte = dac_code_ch1_r;
    end else if (sel_reg == 2'd2) begin
      rd_byte = {out_enable_ch1_r, out_enable_ch0_r, joint_conversion_r, 5'h00} | CONTROL_RSVD;
    end else begin
      rd_byte = {7'h00, standby_output_keep_r} | STBY_RSVD;
    end
  end

  // read data captured with the ack
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= {24'h00_0000, rd_byte};
    end
  end
endmodule : dual_dac_control_regs
`default_nettype wire

// *** dv/dac_macro_model.sv ***
// Purpose: far-side model of the two analog converter channels
// Assumes: one clock; a conversion settles in one cycle
// Notes:   an undriven pin shows the inverse of its last level
`timescale 1ns/1ps
`default_nettype none
module dac_macro_model (
  input  wire logic        clock_i,
  input  wire logic [1:0]  conv_en_i,
  input  wire logic [1:0]  drive_en_i,
  input  wire logic [15:0] code_i,
  output logic      [15:0] pin_o
);
  logic [15:0] held_r;
  // converts the presented code in every cycle its conversion enable is set
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 2; i++) begin
      if (conv_en_i[i]) held_r[8*i+:8] <= code_i[8*i+:8];
    end
  end
  // pin driven only by its own enable
  assign pin_o = held_r ^ {{8{!drive_en_i[1]}}, {8{!drive_en_i[0]}}};
endmodule : dac_macro_model
`default_nettype wire

// *** dv/dual_dac_checker.sv ***
// Purpose: port assertions for the converter control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto the block's top module
`timescale 1ns/1ps
`default_nettype none
module dual_dac_checker
  import dac_ctrl_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              srst_i,
  input wire logic              sw_standby_i,
  input wire logic              hw_standby_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic              wb_ack_o,
  input wire logic              conv_en0_o,
  input wire logic              conv_en1_o,
  input wire logic              analog_out_pin0_oe_o,
  input wire logic              analog_out_pin1_oe_o,
  input wire logic [7:0]        code_ch0_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  logic wr0;
  // accepted write of the channel-0 code
  assign wr0 = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0] && !sw_standby_i
    && !hw_standby_i && wb_adr_i == {IDX_CODE_CH0, 2'h0};
  code_write_a: assert property (wr0 |=> code_ch0_o == $past(wb_dat_i[7:0]))
    else $error("code not forwarded");
  ack_timing_a: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack late");
  drive_conv0_a: assert property (analog_out_pin0_oe_o |-> conv_en0_o)
    else $error("ch0 drives without conversion");
  drive_conv1_a: assert property (analog_out_pin1_oe_o |-> conv_en1_o)
    else $error("ch1 drives without conversion");
  joint_ch0_a: assert property (conv_en0_o && !analog_out_pin0_oe_o |-> analog_out_pin1_oe_o)
    else $error("ch0 converts with no enable");
  joint_ch1_a: assert property (conv_en1_o && !analog_out_pin1_oe_o |-> analog_out_pin0_oe_o)
    else $error("ch1 converts with no enable");
  hw_clear_a: assert property (hw_standby_i[*3] |-> code_ch0_o == 8'h00 && !conv_en0_o)
    else $error("hardware standby did not clear");
  rst_clear_a: assert property (disable iff (1'b0) srst_i |=> !conv_en1_o && !analog_out_pin1_oe_o)
    else $error("reset left channel enabled");
  cover property (wr0);
  cover property (hw_standby_i[*3]);
  cover property (conv_en0_o && !analog_out_pin0_oe_o);
endmodule : dual_dac_checker
bind dual_dac_control_regs dual_dac_checker dual_dac_checker_inst (
  .clock_i(clock_i), .srst_i(srst_i), .sw_standby_i(sw_standby_i),
  .hw_standby_i(hw_standby_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .conv_en0_o(conv_en0_o), .conv_en1_o(conv_en1_o),
  .analog_out_pin0_oe_o(analog_out_pin0_oe_o),
  .analog_out_pin1_oe_o(analog_out_pin1_oe_o), .code_ch0_o(code_ch0_o));
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: self-checking bench for the converter control block
// Assumes: ack comes one cycle after a request
// Notes:   each scenario is one task
`timescale 1ns/1ps
`default_nettype none
module tb
  import dac_ctrl_pkg::*;
();
  logic        clock_i, srst_i, sw, hw, req, we, sel0;
  logic [21:0] adr;
  logic [31:0] dat, rdat;
  logic        ack, c0, c1, d0, d1, stby_st;
  logic [7:0]  k0, k1, q;
  logic [15:0] pins;
  int          error_cnt, checks_done;

  dual_dac_control_regs dual_dac_control_regs_inst (
    .clock_i(clock_i), .srst_i(srst_i), .sw_standby_i(sw), .hw_standby_i(hw),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_sel_i({3'h0, sel0}),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .conv_en0_o(c0),
    .conv_en1_o(c1), .analog_out_pin0_oe_o(d0), .analog_out_pin1_oe_o(d1),
    .code_ch0_o(k0), .code_ch1_o(k1), .stby_state_o(stby_st));
  dac_macro_model dac_macro_model_inst (
    .clock_i(clock_i), .conv_en_i({c1, c0}), .drive_en_i({d1, d0}),
    .code_i({k1, k0}), .pin_o(pins));

  // clock at 25 ns
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [19:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    {req, we, adr, dat} <= {1'b1, w, idx, 2'h0, 24'h0, d};
    do begin
      @(posedge clock_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    req <= 1'b0;
    if (n >= 20) chk(8'h00, 8'hFF);
  endtask : xfer

  task automatic rd(input logic [19:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    chk(q, e);
  endtask : rd

  task automatic settle;
    repeat (2) @(posedge clock_i);
    #1;
  endtask : settle

  task automatic hold(input logic [1:0] s);
    @(posedge clock_i);
    {sw, hw} <= s;
    repeat (4) @(posedge clock_i);
    #1;
  endtask : hold

  task automatic t_reset;
    rd(IDX_CODE_CH1, 8'h00);
    rd(IDX_CONTROL, 8'h1F);
    rd(IDX_STBY_CTRL, 8'hFE);
    xfer(1'b1, 20'h00010, 8'h55);
    rd(20'h00010, 8'h00);
  endtask : t_reset

  task automatic t_code;
    xfer(1'b1, IDX_CONTROL, 8'hC0);
    xfer(1'b1, IDX_CODE_CH0, 8'hA5);
    xfer(1'b1, IDX_CODE_CH1, 8'h3C);
    settle;
    chk(k1, 8'h3C);
    chk(pins[7:0], 8'hA5);
    chk(pins[15:8], 8'h3C);
    sel0 <= 1'b0;
    xfer(1'b1, IDX_CODE_CH0, 8'h5A);
    sel0 <= 1'b1;
    rd(IDX_CODE_CH0, 8'hA5);
  endtask : t_code

  task automatic t_decode;
    logic [2:0] b;
    logic [7:0] e;
    for (int i = 0; i < 8; i++) begin
      b = i[2:0];
      e = {4'h0, b[2] | b[0] & b[1], b[1] | b[0] & b[2], b[2:1]};
      xfer(1'b1, IDX_CONTROL, {b, 5'h00});
      settle;
      chk({4'h0, c1, c0, d1, d0}, e);
      rd(IDX_CONTROL, {b, 5'h1F});
    end
  endtask : t_decode

  task automatic t_standby;
    xfer(1'b1, IDX_CODE_CH0, 8'h77);
    xfer(1'b1, IDX_CONTROL, 8'h40);
    hold(2'h2);
    chk({k0[6:0], d0}, 8'h00);
    chk({7'h00, stby_st}, 8'h01);
    hold(2'h0);
    chk({7'h00, stby_st}, 8'h00);
    rd(IDX_CONTROL, 8'h1F);
    xfer(1'b1, IDX_STBY_CTRL, 8'h01);
    xfer(1'b1, IDX_CODE_CH0, 8'h77);
    xfer(1'b1, IDX_CONTROL, 8'h40);
    hold(2'h2);
    chk(pins[7:0], 8'h77);
    hold(2'h0);
    rd(IDX_STBY_CTRL, 8'hFF);
    hold(2'h1);
    hold(2'h0);
    rd(IDX_STBY_CTRL, 8'hFE);
  endtask : t_standby

  task automatic report_and_stop;
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop

  // main sequence
  initial begin
    {srst_i, sw, hw, req, we, sel0, adr, dat} = {6'h21, 54'h0};
    error_cnt = 0;
    checks_done = 0;
    repeat (2) @(posedge clock_i);
    srst_i <= 1'b0;
    t_reset();
    t_code();
    t_decode();
    t_standby();
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge clock_i);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
